//--- rtl/scm_pkg.sv
// scm_pkg: constants of the speed command mapper
// assumes a 20 MHz clock and a byte-addressed plain register port
package scm_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int PULSE_STOP_US  = 10000;
  localparam int FREQ_STOP_US   = 10000;
  localparam int SLEEP_DELAY_US = 5000;
  localparam int PULSE_STOP_CYC = PULSE_STOP_US * 1000 / CLK_PERIOD_NS;
  localparam int FREQ_STOP_CYC  = FREQ_STOP_US * 1000 / CLK_PERIOD_NS;
  localparam int SLEEP_CYC      = SLEEP_DELAY_US * 1000 / CLK_PERIOD_NS;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_HOST   = 8'h04;
  localparam logic [7:0] OFS_THR    = 8'h08;
  localparam logic [7:0] OFS_MAXSPD = 8'h0c;
  localparam logic [7:0] OFS_ANA    = 8'h10;
  localparam logic [7:0] OFS_GAIN   = 8'h14;
  localparam logic [7:0] OFS_FREQFS = 8'h18;
  localparam logic [7:0] OFS_SLEEP  = 8'h1c;
  localparam logic [7:0] OFS_STAT   = 8'h20;
  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int CTRL_SRC_LSB   = 0;
  localparam int CTRL_LOOP_BIT  = 2;
  localparam int CTRL_RANGE_LSB = 3;
  localparam int HI_LSB         = 16;
  localparam int STAT_STOP_BIT  = 16;
  localparam int STAT_STBY_BIT  = 17;
  localparam int STAT_SLEEP_BIT = 18;
  localparam int GAIN_SH        = 8;
  // ----------------------------------------
  // speed source codes and duty scale
  // ----------------------------------------
  localparam logic [1:0] SRC_ANA  = 2'h0;
  localparam logic [1:0] SRC_PWM  = 2'h1;
  localparam logic [1:0] SRC_HOST = 2'h2;
  localparam logic [1:0] SRC_FREQ = 2'h3;
  localparam logic [9:0] DUTY_FULL = 10'h3ff;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [4:0]  RST_CTRL   = 5'h00;
  localparam logic [9:0]  RST_STOP   = 10'h019;
  localparam logic [9:0]  RST_FLOOR  = 10'h033;
  localparam logic [15:0] RST_MAXSPD = 16'h03e8;
  localparam logic [9:0]  RST_ANA_SB = 10'h020;
  localparam logic [9:0]  RST_ANA_FS = 10'h3c0;
  localparam logic [11:0] RST_GAIN   = 12'h123;
  localparam logic [15:0] RST_FREQFS = 16'h0064;
  localparam logic [9:0]  RST_SL_EN  = 10'h010;
  localparam logic [9:0]  RST_SL_EX  = 10'h020;
endpackage

//--- rtl/scm_mapper.sv
// scm_mapper: speed command front end of a sensorless motor driver
// assumes speed_pin_i is asynchronous and ana_level_i is a sampled
// level already on clk_i
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module scm_mapper #(
  parameter int PULSE_STOP_CYC = scm_pkg::PULSE_STOP_CYC,
  parameter int FREQ_STOP_CYC  = scm_pkg::FREQ_STOP_CYC,
  parameter int SLEEP_CYC      = scm_pkg::SLEEP_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // speed inputs
  input  wire logic        speed_pin_i,
  input  wire logic [9:0]  ana_level_i,
  // commands
  output logic      [9:0]  duty_cmd_o,
  output logic      [15:0] speed_ref_o,
  output logic      [9:0]  target_duty_o,
  output logic             motor_stop_o,
  output logic             sleep_o,
  output logic             standby_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [9:0] ana_map(input logic [9:0] v, input logic [9:0] sb,
                                          input logic [9:0] fs, input logic [11:0] g);
    logic [21:0] p;
    p = {12'h000, v - sb} * {10'h000, g};
    if (v < sb)
      return 10'h000;
    else if (v >= fs || p[21:scm_pkg::GAIN_SH] > {4'h0, scm_pkg::DUTY_FULL})
      return scm_pkg::DUTY_FULL;
    else
      return p[scm_pkg::GAIN_SH +: 10];
  endfunction

  function automatic logic [15:0] spd_scale(input logic [9:0] d, input logic [15:0] m);
    logic [25:0] p;
    p = {16'h0000, d} * {10'h000, m};
    return p[25:10];
  endfunction

  localparam logic [19:0] PSTOP = 20'(PULSE_STOP_CYC);
  localparam logic [19:0] FSTOP = 20'(FREQ_STOP_CYC);
  localparam logic [19:0] SLDLY = 20'(SLEEP_CYC);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [1:0]  src_r;
  logic        loop_r;
  logic [1:0]  range_r;
  logic [9:0]  host_duty_r;
  logic [9:0]  stop_thr_r;
  logic [9:0]  floor_r;
  logic [15:0] max_spd_r;
  logic [9:0]  ana_sb_r;
  logic [9:0]  ana_fs_r;
  logic [11:0] gain_r;
  logic [15:0] freq_fs_r;
  logic [9:0]  sl_en_r;
  logic [9:0]  sl_ex_r;
  logic [31:0] rdata_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      {range_r, loop_r, src_r} <= scm_pkg::RST_CTRL;
      host_duty_r <= 10'h000;
      stop_thr_r  <= scm_pkg::RST_STOP;
      floor_r     <= scm_pkg::RST_FLOOR;
      max_spd_r   <= scm_pkg::RST_MAXSPD;
      ana_sb_r    <= scm_pkg::RST_ANA_SB;
      ana_fs_r    <= scm_pkg::RST_ANA_FS;
      gain_r      <= scm_pkg::RST_GAIN;
      freq_fs_r   <= scm_pkg::RST_FREQFS;
      sl_en_r     <= scm_pkg::RST_SL_EN;
      sl_ex_r     <= scm_pkg::RST_SL_EX;
    end else if (wr_i) begin
      case (addr_i)
        scm_pkg::OFS_CTRL: begin
          src_r   <= wdata_i[scm_pkg::CTRL_SRC_LSB +: 2];
          loop_r  <= wdata_i[scm_pkg::CTRL_LOOP_BIT];
          range_r <= wdata_i[scm_pkg::CTRL_RANGE_LSB +: 2];
        end
        scm_pkg::OFS_HOST: host_duty_r <= wdata_i[9:0];
        scm_pkg::OFS_THR: begin
          stop_thr_r <= wdata_i[9:0];
          floor_r    <= wdata_i[scm_pkg::HI_LSB +: 10];
        end
        scm_pkg::OFS_MAXSPD: max_spd_r <= wdata_i[15:0];
        scm_pkg::OFS_ANA: begin
          ana_sb_r <= wdata_i[9:0];
          ana_fs_r <= wdata_i[scm_pkg::HI_LSB +: 10];
        end
        scm_pkg::OFS_GAIN:   gain_r    <= wdata_i[11:0];
        scm_pkg::OFS_FREQFS: freq_fs_r <= wdata_i[15:0];
        scm_pkg::OFS_SLEEP: begin
          sl_en_r <= wdata_i[9:0];
          sl_ex_r <= wdata_i[scm_pkg::HI_LSB +: 10];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // pin synchroniser and filter
  // ----------------------------------------
  logic [2:0] pin_s_r;
  logic       pin_f_r;
  logic       pin_d_r;
  logic       rise;

  // three stages, change taken when last two agree
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_s_r <= 3'h0;
      pin_f_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      pin_s_r <= {pin_s_r[1:0], speed_pin_i};
      pin_f_r <= (pin_s_r[1] == pin_s_r[2]) ? pin_s_r[2] : pin_f_r;
      pin_d_r <= pin_f_r;
    end
  end

  assign rise = pin_f_r & ~pin_d_r;

  // ----------------------------------------
  // period, high time and low timeout
  // ----------------------------------------
  logic [5:0]  pre_r;
  logic        tick;
  logic [15:0] per_cnt_r;
  logic [15:0] hi_cnt_r;
  logic [15:0] per_cap_r;
  logic [15:0] hi_cap_r;
  logic        meas_ok_r;
  logic [19:0] low_cnt_r;
  logic        start_r;

  // range select sets the measurement prescaler
  always_comb begin
    case (range_r)
      2'h0:    tick = 1'b1;
      2'h1:    tick = (pre_r[1:0] == 2'h0);
      2'h2:    tick = (pre_r[3:0] == 4'h0);
      default: tick = (pre_r == 6'h00);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pre_r     <= 6'h00;
      per_cnt_r <= 16'h0000;
      hi_cnt_r  <= 16'h0000;
      per_cap_r <= 16'h0000;
      hi_cap_r  <= 16'h0000;
      meas_ok_r <= 1'b0;
      start_r   <= 1'b0;
    end else begin
      pre_r   <= rise ? 6'h00 : pre_r + 6'h01;
      start_r <= rise & meas_ok_r;
      if (rise) begin
        per_cap_r <= per_cnt_r;
        hi_cap_r  <= hi_cnt_r;
        meas_ok_r <= 1'b1;
        per_cnt_r <= 16'h0001;
        hi_cnt_r  <= 16'h0001;
      end else if (tick) begin
        if (per_cnt_r != 16'hffff)
          per_cnt_r <= per_cnt_r + 16'h0001;
        if (pin_f_r && hi_cnt_r != 16'hffff)
          hi_cnt_r <= hi_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i)
      low_cnt_r <= 20'h00000;
    else if (pin_f_r)
      low_cnt_r <= 20'h00000;
    else if (low_cnt_r != 20'hfffff)
      low_cnt_r <= low_cnt_r + 20'h00001;
  end

  // ----------------------------------------
  // ratio divider: quotient = num * 1024 / den
  // ----------------------------------------
  logic [15:0] num;
  logic [16:0] rem_r;
  logic [15:0] den_r;
  logic [9:0]  quo_r;
  logic [3:0]  it_r;
  logic        busy_r;
  logic [9:0]  meas_r;
  logic [16:0] rem_sh;
  logic        fit;

  // pulse uses high time over period
  // frequency uses full-scale period over period
  assign num    = (src_r == scm_pkg::SRC_PWM) ? hi_cap_r : freq_fs_r;
  assign rem_sh = {rem_r[15:0], 1'b0};
  assign fit    = rem_sh >= {1'b0, den_r};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rem_r  <= 17'h00000;
      den_r  <= 16'h0000;
      quo_r  <= 10'h000;
      it_r   <= 4'h0;
      busy_r <= 1'b0;
      meas_r <= 10'h000;
    end else if (start_r) begin
      // ratio at or above one clamps at full
      if (num >= per_cap_r || per_cap_r == 16'h0000) begin
        meas_r <= scm_pkg::DUTY_FULL;
        busy_r <= 1'b0;
      end else begin
        rem_r  <= {1'b0, num};
        den_r  <= per_cap_r;
        quo_r  <= 10'h000;
        it_r   <= 4'h0;
        busy_r <= 1'b1;
      end
    end else if (busy_r) begin
      rem_r <= fit ? rem_sh - {1'b0, den_r} : rem_sh;
      quo_r <= {quo_r[8:0], fit};
      it_r  <= it_r + 4'h1;
      if (it_r == 4'h9) begin
        busy_r <= 1'b0;
        meas_r <= {quo_r[8:0], fit};
      end
    end
  end

  // ----------------------------------------
  // sleep and standby in host mode
  // ----------------------------------------
  logic        host_md;
  logic [19:0] slp_cnt_r;
  logic        sleep_r;
  logic        stby_r;

  assign host_md = (src_r == scm_pkg::SRC_HOST);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      slp_cnt_r <= 20'h00000;
      sleep_r   <= 1'b0;
    end else if (!host_md) begin
      slp_cnt_r <= 20'h00000;
      sleep_r   <= 1'b0;
    end else if (ana_level_i > sl_ex_r) begin
      slp_cnt_r <= 20'h00000;
      sleep_r   <= 1'b0;
    end else if (ana_level_i < sl_en_r) begin
      if (slp_cnt_r != 20'hfffff)
        slp_cnt_r <= slp_cnt_r + 20'h00001;
      if (slp_cnt_r >= SLDLY)
        sleep_r <= 1'b1;
    end else begin
      slp_cnt_r <= 20'h00000;
    end
  end

  // awake host mode with zero duty is standby
  always_ff @(posedge clk_i) begin
    if (reset_i)
      stby_r <= 1'b0;
    else
      stby_r <= host_md && !sleep_r && host_duty_r == 10'h000;
  end

  // ----------------------------------------
  // source multiplexer
  // ----------------------------------------
  logic [9:0] cmd_nxt;
  logic [9:0] cmd_r;

  always_comb begin
    case (src_r)
      scm_pkg::SRC_ANA:  cmd_nxt = ana_map(ana_level_i, ana_sb_r, ana_fs_r, gain_r);
      scm_pkg::SRC_PWM:  cmd_nxt = (low_cnt_r >= PSTOP) ? 10'h000 : meas_r;
      scm_pkg::SRC_HOST: cmd_nxt = sleep_r ? 10'h000 : host_duty_r;
      scm_pkg::SRC_FREQ: cmd_nxt = (low_cnt_r >= FSTOP) ? 10'h000 : meas_r;
      default:           cmd_nxt = 10'h000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i)
      cmd_r <= 10'h000;
    else
      cmd_r <= cmd_nxt;
  end

  // ----------------------------------------
  // command to reference or target
  // ----------------------------------------
  logic [9:0]  eff;
  logic [15:0] spd_r;
  logic [9:0]  tgt_r;
  logic        stop_r;

  assign eff = (cmd_r < floor_r) ? floor_r : cmd_r;

  // steady values only; ramps are shaped downstream
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      spd_r  <= 16'h0000;
      tgt_r  <= 10'h000;
      stop_r <= 1'b1;
    end else if (cmd_r < stop_thr_r) begin
      spd_r  <= 16'h0000;
      tgt_r  <= 10'h000;
      stop_r <= 1'b1;
    end else begin
      // loop on gives speed, off gives duty
      spd_r  <= loop_r ? spd_scale(eff, max_spd_r) : 16'h0000;
      tgt_r  <= loop_r ? 10'h000 : eff;
      stop_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        scm_pkg::OFS_CTRL:   rdata_r <= {27'h0, range_r, loop_r, src_r};
        scm_pkg::OFS_HOST:   rdata_r <= {22'h0, host_duty_r};
        scm_pkg::OFS_THR:    rdata_r <= {6'h0, floor_r, 6'h0, stop_thr_r};
        scm_pkg::OFS_MAXSPD: rdata_r <= {16'h0, max_spd_r};
        scm_pkg::OFS_ANA:    rdata_r <= {6'h0, ana_fs_r, 6'h0, ana_sb_r};
        scm_pkg::OFS_GAIN:   rdata_r <= {20'h0, gain_r};
        scm_pkg::OFS_FREQFS: rdata_r <= {16'h0, freq_fs_r};
        scm_pkg::OFS_SLEEP:  rdata_r <= {6'h0, sl_ex_r, 6'h0, sl_en_r};
        scm_pkg::OFS_STAT:   rdata_r <= {13'h0, sleep_r, stby_r, stop_r, 6'h0, cmd_r};
        default:             rdata_r <= 32'h00000000;
      endcase
    end else begin
      rdata_r <= 32'h00000000;
    end
  end

  assign rdata_o       = rdata_r;
  assign duty_cmd_o    = cmd_r;
  assign speed_ref_o   = spd_r;
  assign target_duty_o = tgt_r;
  assign motor_stop_o  = stop_r;
  assign sleep_o       = sleep_r;
  assign standby_o     = stby_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_wake;
    host_md && ana_level_i > sl_ex_r;
  endsequence

  sequence s_run_host;
    !sleep_r ##1 cmd_r == $past(host_duty_r);
  endsequence

  a_ana_zero_low: assert property (@(posedge clk_i) disable iff (reset_i)
    src_r == scm_pkg::SRC_ANA && ana_level_i < ana_sb_r |=> cmd_r == 10'h000)
    else $error("analog below standby not zero");

  a_ana_clamp_full: assert property (@(posedge clk_i) disable iff (reset_i)
    src_r == scm_pkg::SRC_ANA && ana_level_i >= ana_fs_r && ana_level_i >= ana_sb_r
    |=> cmd_r == scm_pkg::DUTY_FULL)
    else $error("analog above full scale not clamped");

  a_pwm_stop_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    src_r == scm_pkg::SRC_PWM && !pin_f_r && low_cnt_r >= PSTOP |=> cmd_r == 10'h000)
    else $error("pulse timeout did not stop");

  a_freq_stop_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    src_r == scm_pkg::SRC_FREQ && !pin_f_r && low_cnt_r >= FSTOP |=> cmd_r == 10'h000)
    else $error("frequency timeout did not stop");

  a_host_wake_run: assert property (@(posedge clk_i) disable iff (reset_i)
    s_wake ##1 host_md |-> s_run_host)
    else $error("host duty not followed after wake");

  a_sleep_no_early: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(sleep_r) |-> $past(slp_cnt_r) >= SLDLY && $past(ana_level_i) < $past(sl_en_r))
    else $error("sleep entered before delay");

  a_standby_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    host_md && !sleep_r && host_duty_r == 10'h000 ##1 host_md && host_duty_r == 10'h000
    |-> stby_r ##1 cmd_r == 10'h000)
    else $error("standby not shown for zero host duty");

  a_stop_below_thr: assert property (@(posedge clk_i) disable iff (reset_i)
    cmd_r < stop_thr_r |=> motor_stop_o && spd_r == 16'h0000 && tgt_r == 10'h000)
    else $error("not stopped below threshold");

  a_floor_hold_off: assert property (@(posedge clk_i) disable iff (reset_i)
    !loop_r && cmd_r >= stop_thr_r && cmd_r < floor_r |=> tgt_r == $past(floor_r))
    else $error("target not held at floor");

  a_loop_off_track: assert property (@(posedge clk_i) disable iff (reset_i)
    !loop_r && cmd_r >= stop_thr_r && cmd_r >= floor_r |=> tgt_r == $past(cmd_r) && !motor_stop_o)
    else $error("target does not equal command");

  a_full_top_speed: assert property (@(posedge clk_i) disable iff (reset_i)
    loop_r && cmd_r == scm_pkg::DUTY_FULL && stop_thr_r <= cmd_r
    |=> spd_r <= $past(max_spd_r) && spd_r + 16'h0001 + ($past(max_spd_r) >> 10) >= $past(max_spd_r))
    else $error("full command is not top speed");
endmodule

//--- testbench/scm_pin_model.sv
// scm_pin_model: host side driving the speed pin
// assumes pin changes only after a rising clock edge
`timescale 1ns/10ps
module scm_pin_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // waveform setup
  input  wire logic        run_i,
  input  wire logic [15:0] high_i,
  input  wire logic [15:0] period_i,
  // pin
  output logic             pin_o
);
  // ----------------------------------------
  // waveform generator
  // ----------------------------------------
  logic [15:0] cnt_r;
  // pin rests low outside waveforms so the stop timeouts can run
  always_ff @(posedge clk_i) begin
    if (reset_i || !run_i || cnt_r >= period_i - 16'h0001) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    pin_o <= !reset_i && run_i && (cnt_r < high_i);
  end
endmodule

//--- testbench/speed_command_mapper_tb.sv
// speed_command_mapper_tb: register and speed path tests of scm_mapper
// assumes the design's small timeout parameters set below
`timescale 1ns/10ps
module speed_command_mapper_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic        pin;
  logic [9:0]  ana_level_i = 10'h000;
  logic [9:0]  duty_cmd_o;
  logic [15:0] speed_ref_o;
  logic [9:0]  target_duty_o;
  logic        motor_stop_o;
  logic        sleep_o;
  logic        standby_o;
  logic        run = 1'b0;
  logic [15:0] high = 16'h0000;
  logic [15:0] period = 16'h0064;
  int          bad_count = 0;
  int          num_checks = 0;

  always #25 clk_i = ~clk_i;

  scm_mapper #(.PULSE_STOP_CYC(50), .FREQ_STOP_CYC(300), .SLEEP_CYC(40)) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .speed_pin_i(pin), .ana_level_i(ana_level_i),
    .duty_cmd_o(duty_cmd_o), .speed_ref_o(speed_ref_o), .target_duty_o(target_duty_o),
    .motor_stop_o(motor_stop_o), .sleep_o(sleep_o), .standby_o(standby_o));

  scm_pin_model u_pin (.clk_i(clk_i), .reset_i(reset_i), .run_i(run), .high_i(high),
    .period_i(period), .pin_o(pin));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic outs(input logic [9:0] d, input logic [15:0] s, input logic [9:0] t, input logic st);
    chk(32'(duty_cmd_o), 32'(d));
    chk(32'(speed_ref_o), 32'(s));
    chk(32'(target_duty_o), 32'(t));
    chk(32'(motor_stop_o), 32'(st));
  endtask
  task automatic ana(input logic [9:0] v);
    @(posedge clk_i);
    ana_level_i <= v;
    wait_cyc(5);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    wait_cyc(20000);
    bad_count++;
    summarize();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(scm_pkg::OFS_THR, 32'h00330019);
    rd(scm_pkg::OFS_MAXSPD, 32'h000003e8);
    rd(scm_pkg::OFS_STAT, 32'h00010000);
    rd(8'h24, 32'h0);
    // analog limits
    ana(10'h010);
    outs(10'h000, 16'h0, 10'h000, 1'b1);
    ana(10'h120);
    outs(10'h123, 16'h0, 10'h123, 1'b0);
    ana(10'h3ff);
    outs(10'h3ff, 16'h0, 10'h3ff, 1'b0);
    ana(10'h03c);
    outs(10'h01f, 16'h0, 10'h033, 1'b0);
    // speed loop on
    wr(scm_pkg::OFS_CTRL, 32'h4);
    wait_cyc(3);
    outs(10'h01f, 16'h0031, 10'h000, 1'b0);
    ana(10'h3ff);
    outs(10'h3ff, 16'h03e7, 10'h000, 1'b0);
    ana(10'h030);
    outs(10'h012, 16'h0000, 10'h000, 1'b1);
    // host duty mode
    wr(scm_pkg::OFS_CTRL, 32'h2);
    wr(scm_pkg::OFS_HOST, 32'h200);
    ana(10'h100);
    outs(10'h200, 16'h0, 10'h200, 1'b0);
    wr(scm_pkg::OFS_HOST, 32'h0);
    wait_cyc(4);
    chk(32'(standby_o), 32'h1);
    chk(32'(duty_cmd_o), 32'h0);
    rd(scm_pkg::OFS_STAT, 32'h00030000);
    wr(scm_pkg::OFS_HOST, 32'h200);
    ana(10'h008);
    wait_cyc(60);
    chk(32'(sleep_o), 32'h1);
    chk(32'(duty_cmd_o), 32'h0);
    rd(scm_pkg::OFS_STAT, 32'h00050000);
    ana(10'h100);
    chk(32'(sleep_o), 32'h0);
    chk(32'(duty_cmd_o), 32'h200);
    // pulse duty mode
    wr(scm_pkg::OFS_CTRL, 32'h1);
    high   <= 16'h003c;
    period <= 16'h0064;
    run    <= 1'b1;
    wait_cyc(400);
    outs(10'h266, 16'h0, 10'h266, 1'b0);
    run <= 1'b0;
    wait_cyc(100);
    outs(10'h000, 16'h0, 10'h000, 1'b1);
    // frequency mode
    wr(scm_pkg::OFS_CTRL, 32'h3);
    high   <= 16'h0064;
    period <= 16'h00c8;
    run    <= 1'b1;
    wait_cyc(700);
    chk(32'(duty_cmd_o), 32'h200);
    wr(scm_pkg::OFS_CTRL, 32'h0b);
    wait_cyc(1000);
    chk(32'(duty_cmd_o), 32'h3ff);
    // slower prescalers with a small full-scale period
    wr(scm_pkg::OFS_FREQFS, 32'h6);
    wr(scm_pkg::OFS_CTRL, 32'h13);
    wait_cyc(1000);
    outs(10'h1b6, 16'h0, 10'h1b6, 1'b0);
    wr(scm_pkg::OFS_FREQFS, 32'h2);
    wr(scm_pkg::OFS_CTRL, 32'h1b);
    wait_cyc(1000);
    outs(10'h199, 16'h0, 10'h199, 1'b0);
    run <= 1'b0;
    wait_cyc(400);
    outs(10'h000, 16'h0, 10'h000, 1'b1);
    summarize();
  end
endmodule
